// [rtl/dcfu_defines.vh]
`ifndef DCFU_DEFINES_VH
`define DCFU_DEFINES_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define DCFU_ADDR_DEBUG_CONTROL   32'h40015804
`define DCFU_ADDR_APB1_FREEZE     32'h40015808
`define DCFU_ADDR_APB2_CLOCK_EN   32'h40021034
// ----------------------------------------
// debug control fields
// ----------------------------------------
`define DCFU_BIT_SLEEP            0
`define DCFU_BIT_STOP             1
`define DCFU_BIT_STANDBY          2
`define DCFU_BIT_TRACE_EN         5
`define DCFU_BIT_TRACE_MODE_LO    6
`define DCFU_BIT_TRACE_MODE_HI    7
`define DCFU_BIT_INDEPENDENT_WATCHDOG             8
`define DCFU_BIT_WINDOW_WATCHDOG             9
`define DCFU_BIT_FREEZE_LO        10
`define DCFU_BIT_FREEZE_HI        21
`define DCFU_BIT_DBG_CLK_EN       22
// writable bits of the control word, others read zero
`define DCFU_CTRL_MASK            32'h003FFFE7
`define DCFU_APB1_MASK            32'h00000001
`define DCFU_APB2_MASK            32'h00400000
`define DCFU_RESET_VALUE          32'h00000000
`endif

// [rtl/dcfu_freeze_gate.v]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// per-bit halt freeze gate
// ----------------------------------------
module dcfu_freeze_gate #(
    parameter WIDTH = 15
) (
    input  wire             i_ref_clk,   // system clock
    input  wire             i_rst_b,     // sync reset, active low
    input  wire [WIDTH-1:0] i_enable,    // freeze bits
    input  wire             i_halted,    // core halted, synchronised
    output reg  [WIDTH-1:0] o_freeze     // registered freeze lines
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_gate
            // R13 - gate by halt
            always @(posedge i_ref_clk) begin
                if (!i_rst_b) begin
                    o_freeze[g] <= 1'b0;
                end else begin
                    o_freeze[g] <= i_enable[g] & i_halted;
                end
            end
        end
    endgenerate
endmodule // dcfu_freeze_gate
`default_nettype wire

// [rtl/dcfu_top.v]
//Operation
// R1 - debug registers survive system resets, cleared only by power-on reset
// R2 - writer enables debug bus clock, bit 22, before configuring
// R3 - sleep, stop, standby keep bits at 0,1,2; value 7 sets all
// R4 - keep bits hold debug link alive in low-power modes
// R5 - keep bits left set raise low-power current; release clears them
// R6 - trace enable bit 5, trace mode bits 7-6, reset zero
// R7 - watchdog freeze bits 8 and 9 stop watchdogs while halted
// R8 - timer, CAN and SMBus timeout freeze bits at 10-21
// R9 - control register at 0x40015804 takes full word writes
// R10 - APB1 freeze register at 0x40015808, bit 0 freezes timer 2
// R11 - each bit set and cleared independently, no side effects
// R12 - probe holds external reset while connecting if link disabled
// R13 - freeze output only when bit set and core halted
`timescale 1ns/1ps
`default_nettype none
`include "dcfu_defines.vh"
module dcfu_top (
    input  wire        i_ref_clk,        // 10 MHz system clock
    input  wire        i_rst_b,          // power-on reset, sync, active low
    input  wire        i_sys_rst_b,      // system reset, does not clear regs
    input  wire        i_wr,             // write strobe
    input  wire        i_rd,             // read strobe
    input  wire [31:0] i_addr,           // byte address
    input  wire [31:0] i_wdata,          // write data
    input  wire        i_halted,         // core debug halt, async
    input  wire        i_sleep,          // core in sleep, async
    input  wire        i_stop,           // core in stop, async
    input  wire        i_standby,        // core in standby, async
    output reg  [31:0] o_rdata,          // read data
    output reg         o_rvalid,         // read data valid pulse
    output reg         o_debug_keep,     // keep debug domain powered
    output reg         o_sleep_debug_keep,    // sleep keep bit
    output reg         o_stop_debug_keep,     // stop keep bit
    output reg         o_standby_debug_keep,  // standby keep bit
    output reg         o_trace_pin_enable,    // trace pins on
    output reg  [1:0]  o_trace_mode,          // trace pin mode
    output reg         o_debug_unit_clock_enable, // debug bus clock on
    output wire [13:0] o_ctrl_freeze,    // watchdog/timer/can/i2c freeze
    output wire        o_timer2_freeze   // APB1 timer 2 freeze
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg  [31:0] debug_control;
    reg  [31:0] apb1_halt_freeze;
    reg  [31:0] apb2_clock_enable;
    reg  [1:0]  halt_sync;
    reg  [1:0]  sleep_sync;
    reg  [1:0]  stop_sync;
    reg  [1:0]  standby_sync;
    wire        clk_on = apb2_clock_enable[`DCFU_BIT_DBG_CLK_EN];

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            halt_sync    <= 2'h0;
            sleep_sync   <= 2'h0;
            stop_sync    <= 2'h0;
            standby_sync <= 2'h0;
        end else begin
            halt_sync    <= {halt_sync[0], i_halted};
            sleep_sync   <= {sleep_sync[0], i_sleep};
            stop_sync    <= {stop_sync[0], i_stop};
            standby_sync <= {standby_sync[0], i_standby};
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // system reset is deliberately ignored so settings persist across it
    // R1 - power-on only clear
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            debug_control     <= `DCFU_RESET_VALUE;
            apb1_halt_freeze  <= `DCFU_RESET_VALUE;
            apb2_clock_enable <= `DCFU_RESET_VALUE;
        end else if (i_wr) begin
            if (i_addr == `DCFU_ADDR_APB2_CLOCK_EN) begin
                apb2_clock_enable <= i_wdata & `DCFU_APB2_MASK;
            end
            // R2 - clock gated writes
            // R9 - word write decode
            // R11 - whole word, masked
            if (clk_on && i_addr == `DCFU_ADDR_DEBUG_CONTROL) begin
                debug_control <= i_wdata & `DCFU_CTRL_MASK;
            end
            // R10 - APB1 freeze write
            if (clk_on && i_addr == `DCFU_ADDR_APB1_FREEZE) begin
                apb1_halt_freeze <= i_wdata & `DCFU_APB1_MASK;
            end
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // unmapped addresses read zero
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_rdata  <= 32'h00000000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            if (!i_rd) begin
                o_rdata <= 32'h00000000;
            end else if (i_addr == `DCFU_ADDR_DEBUG_CONTROL) begin
                o_rdata <= debug_control;
            end else if (i_addr == `DCFU_ADDR_APB1_FREEZE) begin
                o_rdata <= apb1_halt_freeze;
            end else if (i_addr == `DCFU_ADDR_APB2_CLOCK_EN) begin
                o_rdata <= apb2_clock_enable;
            end else begin
                o_rdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // low-power keep and trace outputs
    // ----------------------------------------
    // keep request only while in the matching mode, so a cleared bit
    // lets the debug domain drop and save current
    // R3 - keep bit fields
    // R4 - link kept alive
    // R5 - cleared bits drop power
    // R6 - trace fields
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_debug_keep              <= 1'b0;
            o_sleep_debug_keep        <= 1'b0;
            o_stop_debug_keep         <= 1'b0;
            o_standby_debug_keep      <= 1'b0;
            o_trace_pin_enable        <= 1'b0;
            o_trace_mode              <= 2'h0;
            o_debug_unit_clock_enable <= 1'b0;
        end else begin
            o_sleep_debug_keep   <= debug_control[`DCFU_BIT_SLEEP];
            o_stop_debug_keep    <= debug_control[`DCFU_BIT_STOP];
            o_standby_debug_keep <= debug_control[`DCFU_BIT_STANDBY];
            o_debug_keep <= (sleep_sync[1] & debug_control[`DCFU_BIT_SLEEP])
                          | (stop_sync[1] & debug_control[`DCFU_BIT_STOP])
                          | (standby_sync[1] & debug_control[`DCFU_BIT_STANDBY]);
            o_trace_pin_enable <= debug_control[`DCFU_BIT_TRACE_EN];
            o_trace_mode <= debug_control[`DCFU_BIT_TRACE_MODE_HI:`DCFU_BIT_TRACE_MODE_LO];
            o_debug_unit_clock_enable <= clk_on;
        end
    end

    // ----------------------------------------
    // halt freeze gating
    // ----------------------------------------
    wire [14:0] freeze_en = {apb1_halt_freeze[0],
                             debug_control[`DCFU_BIT_FREEZE_HI:`DCFU_BIT_INDEPENDENT_WATCHDOG]};
    wire [14:0] freeze_q;
    // R7 - watchdog freeze
    // R8 - peripheral freeze
    dcfu_freeze_gate #(
        .WIDTH    (15)
    ) u_gate (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_enable  (freeze_en),
        .i_halted  (halt_sync[1]),
        .o_freeze  (freeze_q)
    );
    assign o_ctrl_freeze   = freeze_q[13:0];
    assign o_timer2_freeze = freeze_q[14];

    // i_sys_rst_b is read only to document that it has no effect
    wire unused_sys_rst = i_sys_rst_b;
endmodule // dcfu_top
`default_nettype wire

// [sim/dcfu_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcfu_defines.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module dcfu_checker (
    input wire logic        i_ref_clk, i_rst_b, i_sys_rst_b, i_wr, i_rd,  // bus side
    input wire logic [31:0] i_addr, i_wdata, o_rdata,                     // words
    input wire logic        i_halted, i_sleep, i_stop, i_standby,        // core state
    input wire logic        o_rvalid, o_debug_keep, o_sleep_debug_keep,   // status
    input wire logic        o_stop_debug_keep, o_standby_debug_keep,      // keep bits
    input wire logic        o_trace_pin_enable, o_debug_unit_clock_enable, // config
    input wire logic [1:0]  o_trace_mode,                                 // trace mode
    input wire logic [13:0] o_ctrl_freeze,                                // freezes
    input wire logic        o_timer2_freeze                               // timer 2
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire [5:0] cfg = {o_trace_mode, o_trace_pin_enable, o_standby_debug_keep, o_stop_debug_keep, o_sleep_debug_keep};
    // config follows writes, survives system reset, clears on power-on reset; read data idles to zero
    reset_clear_a: assert property ($rose(i_rst_b) |-> cfg == 0 && !o_debug_unit_clock_enable)
        else $error("config not cleared by power-on reset");
    sys_reset_hold_a: assert property (!i_sys_rst_b && !i_wr && !$past(i_wr) |=> $stable(cfg))
        else $error("config changed under system reset");
    idle_rdata_a: assert property (!o_rvalid |-> o_rdata == 0)
        else $error("read data not zero outside a read");
    read_answer_a: assert property (i_rd && i_addr == `DCFU_ADDR_DEBUG_CONTROL |=> o_rvalid)
        else $error("no read answer");
    clk_en_write_a: assert property (i_wr && i_addr == `DCFU_ADDR_APB2_CLOCK_EN |-> ##2
        o_debug_unit_clock_enable == $past(i_wdata[22], 2)) else $error("clock enable not written");
    ctrl_write_a: assert property (i_wr && i_addr == `DCFU_ADDR_DEBUG_CONTROL && o_debug_unit_clock_enable
        && $past(o_debug_unit_clock_enable) |-> ##2 cfg == {$past(i_wdata[7:5], 2), $past(i_wdata[2:0], 2)})
        else $error("control bits not written");
    freeze_idle_a: assert property ((!i_halted)[*5] |-> o_ctrl_freeze == 0 && !o_timer2_freeze)
        else $error("freeze while not halted");
    keep_idle_a: assert property ((!(i_sleep || i_stop || i_standby))[*5] |-> !o_debug_keep)
        else $error("keep raised outside low power");
    cover property (o_rvalid && o_rdata != 0);
    cover property (o_ctrl_freeze == 14'h3FFF);
    cover property (o_debug_keep);
endmodule // dcfu_checker
bind dcfu_top dcfu_checker u_chk (.*);
`default_nettype wire

// [sim/dcfu_probe.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcfu_defines.vh"
// ----------------------------------------
// debug probe model
// ----------------------------------------
module dcfu_probe (
    input  wire logic        i_ref_clk, // system clock
    input  wire logic        i_rvalid,  // read answer
    input  wire logic [31:0] i_rdata,   // read data
    output var  logic        o_wr,      // write strobe
    output var  logic        o_rd,      // read strobe
    output var  logic        o_rst_b,   // external reset line
    output var  logic [31:0] o_addr,    // address
    output var  logic [31:0] o_wdata    // write data
);
    initial {o_wr, o_rd, o_rst_b, o_addr, o_wdata} = {3'b001, 64'h0};
    // one-cycle strobe, released bus shows inverted data
    task automatic xfer(input logic w, input logic [31:0] a, d);
        @(negedge i_ref_clk);
        {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(negedge i_ref_clk);
        {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    endtask
    // bounded wait for the read answer
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic ok);
        {ok, d} = 33'h0;
        xfer(0, a, 0);
        repeat (3) begin
            if (!ok && i_rvalid === 1'b1) {ok, d} = {1'b1, i_rdata};
            if (!ok) @(negedge i_ref_clk);
        end
    endtask
    task automatic enable_clk();
        xfer(1, `DCFU_ADDR_APB2_CLOCK_EN, 32'h00400000);
    endtask
    task automatic connect_under_reset();
        o_rst_b = 0;
        enable_clk();
        o_rst_b = 1;
    endtask
endmodule // dcfu_probe
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcfu_defines.vh"
module tb;
    logic        i_ref_clk = 0, i_rst_b = 0, i_halted = 0, i_sleep = 0, i_stop = 0, i_standby = 0;
    logic        i_sys_rst_b, i_wr, i_rd, o_rvalid, o_debug_keep, o_sleep_debug_keep, ok;
    logic        o_stop_debug_keep, o_standby_debug_keep, o_trace_pin_enable, o_debug_unit_clock_enable;
    logic        o_timer2_freeze;
    logic [1:0]  o_trace_mode;
    logic [13:0] o_ctrl_freeze;
    logic [31:0] i_addr, i_wdata, o_rdata, rv;
    int          miscompares = 0, n_compared = 0;
    localparam logic [31:0] CTRL = `DCFU_ADDR_DEBUG_CONTROL, FZ = `DCFU_ADDR_APB1_FREEZE;
    dcfu_top dut (.*);
    dcfu_probe probe (.i_ref_clk(i_ref_clk), .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_wr(i_wr),
        .o_rd(i_rd), .o_rst_b(i_sys_rst_b), .o_addr(i_addr), .o_wdata(i_wdata));
    initial forever #50 i_ref_clk = ~i_ref_clk;
    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [31:0] a, exp);
        probe.rd(a, rv, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t: no read answer", $time);
            print_verdict();
        end else check(rv, exp);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_after_por();
        rchk(CTRL, 0);
        rchk(32'h40015800, 0);
        probe.xfer(1, CTRL, 7);
        rchk(CTRL, 0);
        $display("after_por done");
    endtask
    task automatic t_bits();
        probe.enable_clk();
        rchk(`DCFU_ADDR_APB2_CLOCK_EN, 32'h00400000);
        for (int b = 0; b < 32; b++) begin
            probe.xfer(1, CTRL, 32'h1 << b);
            rchk(CTRL, (32'h1 << b) & `DCFU_CTRL_MASK);
        end
        probe.xfer(1, CTRL, 7);
        rchk(CTRL, 7);
        check({29'h0, o_standby_debug_keep, o_stop_debug_keep, o_sleep_debug_keep}, 7);
        $display("bits done");
    endtask
    task automatic t_freeze();
        probe.xfer(1, FZ, 1);
        rchk(FZ, 1);
        i_halted = 1;
        for (int k = 0; k < 14; k++) begin
            probe.xfer(1, CTRL, 32'h100 << k);
            wait_n(4);
            check({18'h0, o_ctrl_freeze}, 32'h1 << k);
            if (k < 2) check({31'h0, o_ctrl_freeze[k]}, 1);
            check({31'h0, o_timer2_freeze}, 1);
        end
        i_halted = 0;
        wait_n(5);
        check({17'h0, o_timer2_freeze, o_ctrl_freeze}, 0);
        $display("freeze done");
    endtask
    task automatic t_keep();
        for (int m = 0; m < 3; m++) begin
            {i_standby, i_stop, i_sleep} = 3'b001 << m;
            probe.xfer(1, CTRL, 7 ^ (1 << m));
            wait_n(5);
            check({31'h0, o_debug_keep}, 0);
            probe.xfer(1, CTRL, 7);
            wait_n(5);
            check({31'h0, o_debug_keep}, 1);
        end
        probe.xfer(1, CTRL, 0);
        wait_n(5);
        check({31'h0, o_debug_keep}, 0);
        {i_standby, i_stop, i_sleep} = 3'b000;
        $display("keep done");
    endtask
    task automatic t_resets();
        probe.xfer(1, CTRL, 32'h3A7);
        probe.connect_under_reset();
        rchk(CTRL, 32'h3A7);
        check({29'h0, o_trace_mode, o_trace_pin_enable}, 5);
        i_rst_b = 0;
        wait_n(2);
        i_rst_b = 1;
        rchk(CTRL, 0);
        rchk(`DCFU_ADDR_APB2_CLOCK_EN, 0);
        $display("resets done");
    endtask
    initial begin
        wait_n(16);
        i_rst_b = 1;
        t_after_por();
        t_bits();
        t_freeze();
        t_keep();
        t_resets();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
